// file: core/flash_ctl_pkg.sv
// shared constants and types for the flash write/erase control block
package flash_ctl_pkg;
  localparam logic [7:0] PSC_ADDR = 8'h8f;
  localparam logic [7:0] FMC_ADDR = 8'hb6;
  localparam logic [7:0] PSC_RESET = 8'h00;
  localparam logic [7:0] FMC_RESET = 8'h80;
  localparam logic [7:0] FMC_RW_MASK = 8'hc1;
  localparam logic [7:0] PSC_RW_MASK = 8'h07;
  localparam int PSC_WRITE_BIT = 0;
  localparam int PSC_ERASE_BIT = 1;
  localparam int PSC_SCRATCH_BIT = 2;
  localparam int FMC_WRITE_EN_BIT = 0;
  localparam int FMC_READ_ALWAYS_BIT = 6;
  localparam int FMC_ONESHOT_BIT = 7;
  localparam int MAIN_ADDR_W = 16;
  localparam int SCRATCH_ADDR_W = 7;
  localparam int PAGE_ADDR_W = 9;
  localparam int SCRATCH_PAGE_W = 7;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int CLK_MHZ = 250;
  localparam int ONESHOT_NS = 40;
  localparam int ONESHOT_CYC = (ONESHOT_NS * CLK_MHZ) / 1000;
  localparam int WRITE_US = 40;
  localparam int WRITE_CYC = WRITE_US * CLK_MHZ;
  localparam int ERASE_MS = 10;
  localparam int ERASE_CYC = ERASE_MS * 1000 * CLK_MHZ;
  typedef struct packed {
    logic req;
    logic write;
    logic [15:0] addr;
    logic [7:0] data;
  } xdata_req_t;
endpackage

// file: core/flash_array_mem.sv
// byte-wide flash array model with registered read data
`timescale 1ns/1ps
module flash_array_mem #(
  parameter int ADDR_W = 16
) (
  input wire logic clk, // system clock
  input wire logic wr_en, // write one byte
  input wire logic [ADDR_W-1:0] wr_addr, // write address
  input wire logic [7:0] wr_data, // byte to store
  input wire logic [ADDR_W-1:0] rd_addr, // read address
  output logic [7:0] rd_data // registered read byte
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// file: core/flash_write_erase_control.sv
// control for software program and erase of the on-chip flash
// Operation
// RULE1: scratchpad bit routes accesses to 128-byte sector
// RULE2: software keeps scratchpad addresses below 0x80
// RULE3: erase needs both erase and write enables
// RULE4: erase-mode write clears the whole addressed page
// RULE5: data byte ignored during erase
// RULE6: write enable without erase programs one byte
// RULE7: software erases a byte before writing it
// RULE8: program store control resets to zero
// RULE9: flash changes need memory-control write enable
// RULE10: write enable clear sends writes to xdata
// RULE11: erase sets every page byte to ones
// RULE12: byte write clears bits only
// RULE13: one-shot timer or read-always drives sense amps
// RULE14: reserved control bits read as zero
`timescale 1ns/1ps
module flash_write_erase_control #(
  parameter int WRITE_CYCLES = flash_ctl_pkg::WRITE_CYC,
  parameter int ERASE_CYCLES = flash_ctl_pkg::ERASE_CYC
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic sfr_wr, // register write strobe
  input wire logic sfr_rd, // register read strobe
  input wire logic [7:0] sfr_addr, // register address
  input wire logic [7:0] sfr_wdata, // register write data
  output logic [7:0] sfr_rdata, // register read data
  input flash_ctl_pkg::xdata_req_t xreq, // core external-data access
  output logic xreq_ready, // access accepted
  output logic flash_busy, // core stalls while high
  output flash_ctl_pkg::xdata_req_t xdata_out, // access passed to xdata
  input wire logic flash_rd, // core flash read strobe
  input wire logic [15:0] flash_rd_addr, // flash read address
  output logic [7:0] flash_rd_data, // flash read byte
  output logic sense_amp_on // sense amplifiers powered
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROG = 2'b01,
    ST_ERASE = 2'b10
  } op_state_t;

  op_state_t state;
  logic [7:0] psc;
  logic [7:0] fmc;
  logic [31:0] op_cnt;
  logic [15:0] op_addr;
  logic [7:0] op_data;
  logic op_scratch;
  logic [7:0] main_rd;
  logic [7:0] scr_rd;
  logic rd_scratch_q;
  logic [7:0] amp_cnt;

  wire program_write_enable = psc[flash_ctl_pkg::PSC_WRITE_BIT];
  wire erase_enable = psc[flash_ctl_pkg::PSC_ERASE_BIT];
  wire scratchpad_select = psc[flash_ctl_pkg::PSC_SCRATCH_BIT];
  wire flash_write_enable = fmc[flash_ctl_pkg::FMC_WRITE_EN_BIT];
  wire read_oneshot_enable = fmc[flash_ctl_pkg::FMC_ONESHOT_BIT];
  wire read_always_enable = fmc[flash_ctl_pkg::FMC_READ_ALWAYS_BIT];
  wire psc_sel = sfr_addr == flash_ctl_pkg::PSC_ADDR;
  wire fmc_sel = sfr_addr == flash_ctl_pkg::FMC_ADDR;
  wire idle = state == ST_IDLE;
  wire to_flash = program_write_enable; // [RULE10]
  wire flash_wr = xreq.req && xreq.write && to_flash && idle;
  // a flash-bound write with writes disabled is dropped silently
  wire do_erase = flash_wr && erase_enable &&
    flash_write_enable; // [RULE3] [RULE9]
  wire do_prog = flash_wr && !erase_enable &&
    flash_write_enable; // [RULE6] [RULE9]
  wire op_done = !idle && op_cnt == 32'd0;
  wire [15:0] page_base = op_scratch ? 16'h0000 :
    {op_addr[15:flash_ctl_pkg::PAGE_ADDR_W],
     {flash_ctl_pkg::PAGE_ADDR_W{1'b0}}};
  wire [15:0] page_last = op_scratch ?
    16'((1 << flash_ctl_pkg::SCRATCH_ADDR_W) - 1) :
    {op_addr[15:flash_ctl_pkg::PAGE_ADDR_W],
     {flash_ctl_pkg::PAGE_ADDR_W{1'b1}}};
  // spare top bit: erasing the last page must not wrap back to zero
  logic [16:0] erase_ptr;
  wire erasing = state == ST_ERASE;
  // erase walks the page one byte per cycle; the timer covers the rest
  wire [15:0] wr_ptr = erasing ? erase_ptr[15:0] : op_addr;
  wire erase_step = erasing && erase_ptr <= {1'b0, page_last};
  wire [7:0] cur_byte = op_scratch ? scr_rd : main_rd;
  // programming ANDs with current content so bits can only fall
  wire [7:0] prog_byte = op_data & cur_byte; // [RULE12]
  wire [7:0] wr_byte = erasing ? flash_ctl_pkg::ERASED_BYTE :
    prog_byte; // [RULE11] [RULE5]
  wire prog_fire = state == ST_PROG && op_cnt == 32'd1;
  wire mem_we = erase_step || prog_fire;
  wire main_we = mem_we && !op_scratch; // [RULE1]
  wire scr_we = mem_we && op_scratch; // [RULE1]
  wire [15:0] rd_a = idle ? flash_rd_addr : op_addr;
  wire rd_scr = idle ? scratchpad_select : op_scratch;

  assign xreq_ready = idle;
  assign flash_busy = !idle;
  assign flash_rd_data = rd_scratch_q ? scr_rd : main_rd;
  assign sense_amp_on = read_always_enable || !read_oneshot_enable ||
    amp_cnt != 8'd0; // [RULE13]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      psc <= flash_ctl_pkg::PSC_RESET; // [RULE8]
      fmc <= flash_ctl_pkg::FMC_RESET;
    end else if (sfr_wr) begin
      if (psc_sel) psc <= sfr_wdata & flash_ctl_pkg::PSC_RW_MASK;
      if (fmc_sel) fmc <= sfr_wdata & flash_ctl_pkg::FMC_RW_MASK; // [RULE14]
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= psc_sel ? psc : fmc_sel ? fmc : 8'h00;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      op_cnt <= 32'd0;
      op_addr <= 16'h0000;
      op_data <= 8'h00;
      op_scratch <= 1'b0;
      erase_ptr <= 17'h0_0000;
    end else if (idle) begin
      if (do_erase || do_prog) begin
        op_addr <= scratchpad_select ?
          16'(xreq.addr[flash_ctl_pkg::SCRATCH_ADDR_W-1:0]) :
          xreq.addr; // [RULE1] [RULE4]
        op_data <= xreq.data;
        op_scratch <= scratchpad_select;
        erase_ptr <= scratchpad_select ? 17'h0_0000 :
          {1'b0, xreq.addr[15:flash_ctl_pkg::PAGE_ADDR_W],
           {flash_ctl_pkg::PAGE_ADDR_W{1'b0}}}; // [RULE4]
        op_cnt <= do_erase ? 32'(ERASE_CYCLES) : 32'(WRITE_CYCLES);
        state <= do_erase ? ST_ERASE : ST_PROG;
      end
    end else begin
      op_cnt <= op_cnt - 32'd1;
      if (erase_step) erase_ptr <= erase_ptr + 17'd1;
      if (op_done) state <= ST_IDLE;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xdata_out <= '0;
      rd_scratch_q <= 1'b0;
      amp_cnt <= 8'd0;
    end else begin
      xdata_out <= to_flash ? '0 : xreq; // [RULE10]
      rd_scratch_q <= rd_scr;
      if (flash_rd) amp_cnt <= 8'(flash_ctl_pkg::ONESHOT_CYC);
      else if (amp_cnt != 8'd0) amp_cnt <= amp_cnt - 8'd1;
    end
  end

  flash_array_mem #(.ADDR_W(flash_ctl_pkg::MAIN_ADDR_W)) u_main (
    .clk(clk),
    .wr_en(main_we),
    .wr_addr(wr_ptr),
    .wr_data(wr_byte),
    .rd_addr(rd_a),
    .rd_data(main_rd)
  );

  flash_array_mem #(.ADDR_W(flash_ctl_pkg::SCRATCH_ADDR_W)) u_scratch (
    .clk(clk),
    .wr_en(scr_we),
    .wr_addr(wr_ptr[flash_ctl_pkg::SCRATCH_ADDR_W-1:0]),
    .wr_data(wr_byte),
    .rd_addr(rd_a[flash_ctl_pkg::SCRATCH_ADDR_W-1:0]),
    .rd_data(scr_rd)
  );

  chk_reset_zero: assert property (@(posedge clk) // [RULE8]
    $fell(sys_rst) |-> psc == flash_ctl_pkg::PSC_RESET)
    else $error("control register not zero after reset");

  chk_erase_needs_both: assert property (@(posedge clk) // [RULE3]
    disable iff (sys_rst)
    $rose(erasing) |-> $past(erase_enable && program_write_enable))
    else $error("erase started without both enables");

  chk_gate_write_enable: assert property (@(posedge clk) // [RULE9]
    disable iff (sys_rst) (idle && !flash_write_enable) |=> idle)
    else $error("flash op started with writes disabled");

  chk_prog_mode: assert property (@(posedge clk) // [RULE6]
    disable iff (sys_rst) do_prog |=> state == ST_PROG)
    else $error("byte program not started");

  chk_erase_ones: assert property (@(posedge clk) // [RULE11]
    disable iff (sys_rst)
    erase_step |-> wr_byte == flash_ctl_pkg::ERASED_BYTE)
    else $error("erase wrote non-ones");

  chk_bits_fall: assert property (@(posedge clk) // [RULE12]
    disable iff (sys_rst) prog_fire |-> (wr_byte & ~cur_byte) == 8'h00)
    else $error("program raised a bit");

  chk_xdata_route: assert property (@(posedge clk) // [RULE10]
    disable iff (sys_rst)
    (xreq.req && !program_write_enable) |=> xdata_out.req)
    else $error("xdata access not forwarded");

  chk_xdata_blocked: assert property (@(posedge clk) // [RULE10]
    disable iff (sys_rst) program_write_enable |=> !xdata_out.req)
    else $error("flash-bound access leaked to xdata");

  chk_reserved_zero: assert property (@(posedge clk) // [RULE14]
    disable iff (sys_rst) (fmc & ~flash_ctl_pkg::FMC_RW_MASK) == 8'h00)
    else $error("reserved bits nonzero");

  chk_scratch_route: assert property (@(posedge clk) // [RULE1]
    disable iff (sys_rst)
    (idle && do_prog && scratchpad_select) |=> op_scratch)
    else $error("scratchpad not selected");

  // an erase request must start the erase and stall the core on the next cycle
  sequence seq_erase_req;
    idle && do_erase;
  endsequence

  sequence seq_erase_run;
    erasing && flash_busy && !xreq_ready;
  endsequence

  chk_erase_start: assert property (@(posedge clk) // [RULE4]
    disable iff (sys_rst) seq_erase_req |=> seq_erase_run)
    else $error("erase request did not start an erase");

  chk_erase_in_page: assert property (@(posedge clk) // [RULE4]
    disable iff (sys_rst)
    erase_step |-> wr_ptr >= page_base && wr_ptr <= page_last)
    else $error("erase left the addressed page");

  chk_oneshot_on: assert property (@(posedge clk) // [RULE13]
    disable iff (sys_rst) flash_rd |=> sense_amp_on)
    else $error("sense amps off right after a read");

  chk_oneshot_off: assert property (@(posedge clk) // [RULE13]
    disable iff (sys_rst)
    (read_oneshot_enable && !read_always_enable && amp_cnt == 8'd0)
    |-> !sense_amp_on)
    else $error("sense amps left on with the timer expired");
endmodule

// file: verification/core_model.sv
// processor-core stand-in issuing register and external-data accesses
`timescale 1ns/1ps
module core_model (
  input wire logic clk, // system clock
  input wire logic xreq_ready, // access accepted
  output logic sfr_wr, // register write
  output logic sfr_rd, // register read
  output logic [7:0] sfr_addr, // register address
  output logic [7:0] sfr_wdata, // register data
  output flash_ctl_pkg::xdata_req_t xreq, // external-data access
  output logic flash_rd, // flash read
  output logic [15:0] flash_rd_addr // flash read address
);
  initial begin
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, flash_rd, flash_rd_addr} = '0;
    xreq = '0;
  end
  // released buses show the inverse so a stale value cannot pass
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} <= {w, !w, a, d};
    @(posedge clk);
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} <= {2'b00, ~a, ~d};
  endtask
  task automatic xwrite(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    for (int i = 0; i < 50 && xreq_ready !== 1'b1; i++) @(posedge clk);
    xreq <= '{1'b1, 1'b1, a, d};
    @(posedge clk);
    xreq <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic fread(input logic [15:0] a);
    @(posedge clk);
    {flash_rd, flash_rd_addr} <= {1'b1, a};
    @(posedge clk);
    {flash_rd, flash_rd_addr} <= {1'b0, ~a};
  endtask
endmodule

// file: verification/flash_write_erase_control_tb.sv
// self-checking bench for the flash write/erase control block
`timescale 1ns/1ps
module flash_write_erase_control_tb;
  localparam int WR = 20;
  localparam int ER = 600;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sfr_wr, sfr_rd, flash_rd, xreq_ready, flash_busy, sense_amp_on;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, flash_rd_data, d, d2;
  logic [15:0] flash_rd_addr;
  flash_ctl_pkg::xdata_req_t xreq, xdata_out;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_d84b;
  logic [7:0] expq[$];
  logic sfr_seen = 1'b0;
  logic fl_seen = 1'b0;
  always #2 clk = ~clk;
  core_model i_core_model (.clk(clk), .xreq_ready(xreq_ready),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .xreq(xreq), .flash_rd(flash_rd),
    .flash_rd_addr(flash_rd_addr));
  flash_write_erase_control #(.WRITE_CYCLES(WR), .ERASE_CYCLES(ER))
    i_flash_write_erase_control (.clk(clk), .sys_rst(sys_rst),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xreq(xreq),
    .xreq_ready(xreq_ready), .flash_busy(flash_busy),
    .xdata_out(xdata_out), .flash_rd(flash_rd),
    .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data),
    .sense_amp_on(sense_amp_on));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    i_core_model.sfr(1'b0, a, 8'h00);
  endtask
  task automatic rfl(input logic [15:0] a, input logic [7:0] e);
    expq.push_back(e);
    i_core_model.fread(a);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    i_core_model.sfr(1'b1, a, v);
  endtask
  // xd: a copy must reach the external-data side; len: busy cycles
  task automatic xfer(input logic [15:0] a, input logic [7:0] v,
                      input int len, input logic xd);
    int n;
    n = 0;
    repeat (rnd() & 8'h03) @(posedge clk);
    i_core_model.xwrite(a, v);
    #1;
    check("xdata", xd ? {2'b11, a, v} : 26'h0, xdata_out);
    check("ready", 32'(len == 0), xreq_ready);
    while (flash_busy === 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("busy_len", len, n);
  endtask
  // results land on the same edge that takes the read strobe
  always @(posedge clk) begin
    sfr_seen <= sfr_rd;
    fl_seen <= flash_rd;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  always @(negedge clk) begin
    if ((sfr_seen || fl_seen) && expq.size() > 0) begin
      check("read", expq.pop_front(), sfr_seen ? sfr_rdata : flash_rd_data);
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rreg(flash_ctl_pkg::PSC_ADDR, 8'h00);
    rreg(8'h55, 8'h00);
    wreg(flash_ctl_pkg::FMC_ADDR, 8'hff);
    rreg(flash_ctl_pkg::FMC_ADDR, 8'hc1);
    check("sense_on", 24'h1, sense_amp_on);
    wreg(flash_ctl_pkg::PSC_ADDR, 8'hff);
    rreg(flash_ctl_pkg::PSC_ADDR, 8'h07);
    wreg(flash_ctl_pkg::PSC_ADDR, 8'h03);
    xfer(16'h0234, rnd(), ER + 1, 1'b0);
    rfl(16'h0200, 8'hff);
    rfl(16'h03ff, 8'hff);
    wreg(flash_ctl_pkg::PSC_ADDR, 8'h01);
    d = rnd();
    xfer(16'h0300, d, WR + 1, 1'b0);
    rfl(16'h0300, d);
    d2 = rnd();
    xfer(16'h0300, d2, WR + 1, 1'b0);
    d = d & d2;
    rfl(16'h0300, d);
    wreg(flash_ctl_pkg::PSC_ADDR, 8'h02);
    xfer(16'h0300, 8'h00, 0, 1'b1);
    rfl(16'h0300, d);
    wreg(flash_ctl_pkg::FMC_ADDR, 8'h80);
    wreg(flash_ctl_pkg::PSC_ADDR, 8'h03);
    xfer(16'h0300, 8'h00, 0, 1'b0);
    rfl(16'h0300, d);
    wreg(flash_ctl_pkg::FMC_ADDR, 8'h81);
    wreg(flash_ctl_pkg::PSC_ADDR, 8'h07);
    xfer(16'h0010, rnd(), ER + 1, 1'b0);
    wreg(flash_ctl_pkg::PSC_ADDR, 8'h05);
    d2 = rnd();
    xfer(16'h0000, d2, WR + 1, 1'b0);
    rfl(16'h0000, d2);
    wreg(flash_ctl_pkg::PSC_ADDR, 8'h01);
    rfl(16'h0300, d);
    wreg(flash_ctl_pkg::FMC_ADDR, 8'h80);
    rfl(16'h0300, d);
    #1;
    check("sense_shot", 32'h1, sense_amp_on);
    repeat (15) @(posedge clk);
    check("sense_off", 32'h0, sense_amp_on);
    wreg(flash_ctl_pkg::FMC_ADDR, 8'h00);
    #1;
    check("sense_free", 32'h1, sense_amp_on);
    finish_test();
  end
endmodule
